// >>> design/skac_defs.vh
// standby keep-alive control: register offsets, field positions, resets
// assumes inclusion by bare name from the design files
`ifndef SKAC_DEFS_VH
`define SKAC_DEFS_VH

`define SKAC_ADDR_W          8
`define SKAC_DATA_W          16
`define SKAC_MISC_OFFSET     8'h00
`define SKAC_CFG_OFFSET      8'h01
`define SKAC_STAT_OFFSET     8'h02
`define SKAC_MISC_RESET      16'h0000
`define SKAC_MISC_MASK       16'h01FF
`define SKAC_CFG_RESET       16'h0000
`define SKAC_BIT_INTREF      0
`define SKAC_BIT_REFHOL      1
`define SKAC_BIT_IEXC        2
`define SKAC_BIT_BIAS        3
`define SKAC_BIT_OPENW       4
`define SKAC_BIT_LSW         5
`define SKAC_BIT_GOUT        6
`define SKAC_NUM_FUNC        7

`endif

// >>> design/skac_gate.v
// one keep-alive gate: passes a function enable in conversion, and in
// standby only when its keep-alive bit is set; output registered
// assumes mclk and rst are the device clock and register reset
`timescale 1ns/100ps
module skac_gate (
  mclk,
  rst,
  standby,
  keep,
  normal_en,
  gated_q
);
  parameter W = 1;
  input  wire         mclk;      // device clock
  input  wire         rst;       // async reset, active high
  input  wire         standby;   // device in standby
  input  wire         keep;      // keep-alive bit for this function
  input  wire [W-1:0] normal_en; // enable from setup/channel config
  output reg  [W-1:0] gated_q;   // enable actually applied

  wire [W-1:0] gated_d;
  // in conversion the keep bit is ignored
  assign gated_d = (standby && !keep) ? {W{1'b0}} : normal_en;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      gated_q <= {W{1'b0}};
    end else begin
      gated_q <= gated_d;
    end
  end
endmodule // skac_gate

// >>> design/skac_standby_keep_alive.v
// standby keep-alive control: misc control register and enable gating
// assumes synchronous inputs and a register port with read data one
// cycle after the read strobe; setup/channel settings arrive resolved
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/100ps
`include "skac_defs.vh"

// Overview of operation
// - bit 6 keeps enabled general outputs active in standby, else off
// - bit 5 keeps low-side switch following channel setting in standby
// - bit 4 keeps selected open-wire currents on in standby, else off
// - bit 3 keeps bias voltage on selected pins in standby, else off
// - bit 2 keeps configured excitation magnitudes on in standby
// - kept excitation still routes to the channel's configured pins
// - bit 1 keeps reference holder enabled in standby, else disabled
// - bit 0 keeps internal reference and output buffer in standby
module skac_standby_keep_alive (
  mclk,
  rst,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata_q,
  standby,
  general_output_en,
  channel_switch_setting,
  open_wire_en,
  bias_voltage_pin_select,
  setup_excitation_magnitude_a,
  setup_excitation_magnitude_b,
  channel_excitation_route_a,
  channel_excitation_route_b,
  ref_holder_en,
  internal_ref_en,
  general_output_q,
  low_side_switch_q,
  open_wire_q,
  bias_voltage_q,
  excitation_magnitude_a_q,
  excitation_magnitude_b_q,
  excitation_route_a_q,
  excitation_route_b_q,
  ref_holder_q,
  internal_ref_q,
  reference_output_pin_q
);
  input  wire                    mclk;                         // clock
  input  wire                    rst;                          // reset
  input  wire [`SKAC_ADDR_W-1:0] reg_addr;                     // address
  input  wire [`SKAC_DATA_W-1:0] reg_wdata;                    // wr data
  input  wire                    reg_wr;                       // wr strobe
  input  wire                    reg_rd;                       // rd strobe
  output reg  [`SKAC_DATA_W-1:0] reg_rdata_q;                  // rd data
  input  wire                    standby;                      // standby
  input  wire [3:0]              general_output_en;            // gen out ena
  input  wire                    channel_switch_setting;       // sw close
  input  wire                    open_wire_en;                 // ow curr
  input  wire [7:0]              bias_voltage_pin_select;      // per pin
  input  wire [2:0]              setup_excitation_magnitude_a; // mag a
  input  wire [2:0]              setup_excitation_magnitude_b; // mag b
  input  wire [3:0]              channel_excitation_route_a;   // pin a
  input  wire [3:0]              channel_excitation_route_b;   // pin b
  input  wire                    ref_holder_en;                // refhold
  input  wire                    internal_ref_en;              // int ref
  output wire [3:0]              general_output_q;             // gen out ena
  output wire                    low_side_switch_q;            // switch
  output wire                    open_wire_q;                  // ow curr
  output wire [7:0]              bias_voltage_q;               // bias ena
  output wire [2:0]              excitation_magnitude_a_q;     // mag a
  output wire [2:0]              excitation_magnitude_b_q;     // mag b
  output reg  [3:0]              excitation_route_a_q;         // pin a
  output reg  [3:0]              excitation_route_b_q;         // pin b
  output wire                    ref_holder_q;                 // refhold
  output wire                    internal_ref_q;               // int ref
  output wire                    reference_output_pin_q;       // ref buf

  reg  [`SKAC_DATA_W-1:0] misc_control_q;
  reg  [`SKAC_DATA_W-1:0] rdata_d;
  reg                     standby_q;
  wire [`SKAC_DATA_W-1:0] stat_word;

  // bits 7 and 8 of the register are storage only and gate nothing here
  wire keep_internal_ref_in_standby      = misc_control_q[`SKAC_BIT_INTREF];
  wire keep_reference_holder_in_standby  = misc_control_q[`SKAC_BIT_REFHOL];
  wire keep_excitation_in_standby        = misc_control_q[`SKAC_BIT_IEXC];
  wire keep_bias_voltage_in_standby      = misc_control_q[`SKAC_BIT_BIAS];
  wire keep_open_wire_current_in_standby = misc_control_q[`SKAC_BIT_OPENW];
  wire keep_low_side_switch_in_standby   = misc_control_q[`SKAC_BIT_LSW];
  wire keep_outputs_in_standby           = misc_control_q[`SKAC_BIT_GOUT];

  // only the documented bits 8:0 are held; upper bits read zero
  // writes to any other offset, status included, are dropped
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      misc_control_q <= `SKAC_MISC_RESET;
    end else if (reg_wr && reg_addr == `SKAC_MISC_OFFSET) begin
      misc_control_q <= reg_wdata & `SKAC_MISC_MASK;
    end
  end

  // status shows what standby actually left running, not what was asked;
  // it reads the applied enables, so it lags the inputs by one edge
  wire any_mag_a_on = |excitation_magnitude_a_q;
  wire any_mag_b_on = |excitation_magnitude_b_q;
  wire any_gout_on  = |general_output_q;

  assign stat_word = {8'h00, standby_q, ref_holder_q, internal_ref_q,
                      open_wire_q, low_side_switch_q,
                      any_mag_a_on, any_mag_b_on, any_gout_on};

  // read data is zero except in the cycle after a read strobe, so a
  // stale word never looks like a fresh answer
  always @* begin
    rdata_d = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        `SKAC_MISC_OFFSET: rdata_d = misc_control_q;
        `SKAC_STAT_OFFSET: rdata_d = stat_word;
        default:           rdata_d = 16'h0000;
      endcase
    end
  end

  // standby is registered only for the status word; the gates use the raw
  // input so the enables follow standby with a single edge of lag
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata_q <= 16'h0000;
      standby_q   <= 1'b0;
    end else begin
      reg_rdata_q <= rdata_d;
      standby_q   <= standby;
    end
  end

  // routing is unchanged by standby; magnitudes alone gate the current
  // a route with a zero magnitude behind it carries nothing to its pin
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      excitation_route_a_q <= 4'h0;
      excitation_route_b_q <= 4'h0;
    end else begin
      excitation_route_a_q <= channel_excitation_route_a;
      excitation_route_b_q <= channel_excitation_route_b;
    end
  end

  // gating happens at the flop input, so every output leaves a register
  // and a standby edge shows up on the enables exactly one clock later

  // general outputs stay on in standby only when their keep bit is set
  skac_gate #(.W(4)) u_gout (
    .mclk      (mclk),
    .rst       (rst),
    .standby   (standby),
    .keep      (keep_outputs_in_standby),
    .normal_en (general_output_en),
    .gated_q   (general_output_q)
  );

  // a kept switch goes on following the channel's open/close setting
  skac_gate #(.W(1)) u_lsw (
    .mclk      (mclk),
    .rst       (rst),
    .standby   (standby),
    .keep      (keep_low_side_switch_in_standby),
    .normal_en (channel_switch_setting),
    .gated_q   (low_side_switch_q)
  );

  // a kept open-wire current still obeys the setup's own selection
  skac_gate #(.W(1)) u_ow (
    .mclk      (mclk),
    .rst       (rst),
    .standby   (standby),
    .keep      (keep_open_wire_current_in_standby),
    .normal_en (open_wire_en),
    .gated_q   (open_wire_q)
  );

  // bias stays only on the pins that the per-pin selection names
  skac_gate #(.W(8)) u_vb (
    .mclk      (mclk),
    .rst       (rst),
    .standby   (standby),
    .keep      (keep_bias_voltage_in_standby),
    .normal_en (bias_voltage_pin_select),
    .gated_q   (bias_voltage_q)
  );

  // both magnitudes share one keep bit; a zero magnitude means no current
  skac_gate #(.W(6)) u_iex (
    .mclk      (mclk),
    .rst       (rst),
    .standby   (standby),
    .keep      (keep_excitation_in_standby),
    .normal_en ({setup_excitation_magnitude_b,
                 setup_excitation_magnitude_a}),
    .gated_q   ({excitation_magnitude_b_q, excitation_magnitude_a_q})
  );

  // the holder is cut on standby entry unless its keep bit is set
  skac_gate #(.W(1)) u_rh (
    .mclk      (mclk),
    .rst       (rst),
    .standby   (standby),
    .keep      (keep_reference_holder_in_standby),
    .normal_en (ref_holder_en),
    .gated_q   (ref_holder_q)
  );

  // reference and its output buffer switch together
  skac_gate #(.W(2)) u_ref (
    .mclk      (mclk),
    .rst       (rst),
    .standby   (standby),
    .keep      (keep_internal_ref_in_standby),
    .normal_en ({internal_ref_en, internal_ref_en}),
    .gated_q   ({reference_output_pin_q, internal_ref_q})
  );
endmodule // skac_standby_keep_alive

// >>> test/skac_standby_keep_alive_sva.sv
// checker for the standby keep-alive gating, bound to the top module
// assumes the keep bits mirror writes to offset 0x00 one edge later
`timescale 1ns/100ps
module skac_standby_keep_alive_sva (
  input wire        mclk,
  input wire        rst,
  input wire [7:0]  reg_addr,
  input wire [15:0] reg_wdata,
  input wire        reg_wr,
  input wire        standby,
  input wire [3:0]  general_output_en,
  input wire [3:0]  general_output_q,
  input wire        channel_switch_setting,
  input wire        low_side_switch_q,
  input wire        open_wire_en,
  input wire        open_wire_q,
  input wire [7:0]  bias_voltage_pin_select,
  input wire [7:0]  bias_voltage_q,
  input wire [2:0]  setup_excitation_magnitude_a,
  input wire [2:0]  excitation_magnitude_a_q,
  input wire [3:0]  channel_excitation_route_b,
  input wire [3:0]  excitation_route_b_q,
  input wire        ref_holder_en,
  input wire        ref_holder_q,
  input wire        internal_ref_en,
  input wire        reference_output_pin_q
);
  logic [6:0] k_q;
  logic       arm_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // outputs are only comparable once one edge after reset has passed
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      k_q   <= 7'h00;
      arm_q <= 1'b0;
    end else begin
      arm_q <= 1'b1;
      if (reg_wr && reg_addr == 8'h00) k_q <= reg_wdata[6:0];
    end
  end
  a_gout_gate: assert property (arm_q |-> general_output_q ==
    (($past(standby) && !$past(k_q[6])) ? 4'h0 : $past(general_output_en)))
    else $error("general output enable wrong");
  a_switch_off: assert property (arm_q && $past(standby) && !$past(k_q[5])
    |-> !low_side_switch_q) else $error("switch kept in standby");
  a_switch_conv: assert property (arm_q && !$past(standby)
    |-> low_side_switch_q == $past(channel_switch_setting))
    else $error("switch not following setting");
  a_openw_gate: assert property (arm_q |-> open_wire_q ==
    ($past(open_wire_en) && !($past(standby) && !$past(k_q[4]))))
    else $error("open wire current wrong");
  a_bias_gate: assert property (arm_q |-> bias_voltage_q ==
    (($past(standby) && !$past(k_q[3])) ? 8'h00
     : $past(bias_voltage_pin_select))) else $error("bias enable wrong");
  a_mag_gate: assert property (arm_q |-> excitation_magnitude_a_q ==
    (($past(standby) && !$past(k_q[2])) ? 3'h0
     : $past(setup_excitation_magnitude_a))) else $error("magnitude wrong");
  a_route_pass: assert property (arm_q |-> excitation_route_b_q ==
    $past(channel_excitation_route_b)) else $error("route changed");
  a_refhold_gate: assert property (arm_q |-> ref_holder_q ==
    ($past(ref_holder_en) && !($past(standby) && !$past(k_q[1]))))
    else $error("reference holder wrong");
  a_reference_output_pin_gate: assert property (arm_q |-> reference_output_pin_q ==
    ($past(internal_ref_en) && !($past(standby) && !$past(k_q[0]))))
    else $error("reference buffer wrong");
endmodule // skac_standby_keep_alive_sva

bind skac_standby_keep_alive skac_standby_keep_alive_sva i_sva (.*);

// >>> test/skac_standby_keep_alive_bench.sv
// random bench for the keep-alive gating with a reference model
// assumes registered outputs one edge after inputs, keep bits at 0x00
`timescale 1ns/100ps
module skac_standby_keep_alive_bench;
  logic        mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        standby = 1'b0, sp = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, km = 16'h0000, er;
  logic [29:0] ri = 30'h0;
  logic [31:0] rnd;
  logic [30:0] e, ep = 31'h0;
  logic [7:0]  at [4] = '{8'h00, 8'h02, 8'h01, 8'h7F};
  wire  [15:0] reg_rdata_q;
  wire  [7:0]  bias_voltage_pin_select, bias_voltage_q;
  wire  [3:0]  general_output_en, channel_excitation_route_a;
  wire  [3:0]  channel_excitation_route_b, general_output_q;
  wire  [3:0]  excitation_route_a_q, excitation_route_b_q;
  wire  [2:0]  setup_excitation_magnitude_a, setup_excitation_magnitude_b;
  wire  [2:0]  excitation_magnitude_a_q, excitation_magnitude_b_q;
  wire         channel_switch_setting, open_wire_en, ref_holder_en;
  wire         internal_ref_en, low_side_switch_q, open_wire_q;
  wire         ref_holder_q, internal_ref_q, reference_output_pin_q;
  int          n_mismatch = 0, samples_checked = 0;
  assign {general_output_en, channel_switch_setting, open_wire_en,
          bias_voltage_pin_select, setup_excitation_magnitude_a,
          setup_excitation_magnitude_b, channel_excitation_route_a,
          channel_excitation_route_b, ref_holder_en, internal_ref_en} = ri;
  wire [30:0] vout = {general_output_q, low_side_switch_q, open_wire_q,
    bias_voltage_q, excitation_magnitude_a_q, excitation_magnitude_b_q,
    excitation_route_a_q, excitation_route_b_q, ref_holder_q,
    internal_ref_q, reference_output_pin_q};
  // the internal reference bit also gates the reference buffer
  wire [30:0] mk = {{4{km[6]}}, km[5], km[4], {8{km[3]}}, {6{km[2]}},
    8'hFF, km[1], km[0], km[0]};
  skac_standby_keep_alive i_skac_standby_keep_alive (.*);
  always #5 mclk = ~mclk;
  task automatic check(string nm, logic [30:0] ex, logic [30:0] got);
    samples_checked++;
    if (ex !== got) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #40000;
    n_mismatch++;
    test_done();
  end
  initial begin
    void'($urandom(30));
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    repeat (3000) begin
      @(posedge mclk);
      // status shows the enables and standby as they stood before this edge
      er = 16'h0000;
      if (reg_rd && reg_addr == 8'h00) er = km & 16'h01FF;
      if (reg_rd && reg_addr == 8'h02)
        er = {8'h00, sp, ep[2], ep[1], ep[25], ep[26], |ep[16:14],
              |ep[13:11], |ep[30:27]};
      e = standby ? ({ri, ri[0]} & mk) : {ri, ri[0]};
      ep = e;
      sp = standby;
      // upper bits of a write are dropped, other offsets ignored
      if (reg_wr && reg_addr == 8'h00) km = reg_wdata & 16'h01FF;
      rnd = $urandom;
      reg_wr <= rnd[1:0] == 2'b00;
      reg_rd <= rnd[1:0] == 2'b01;
      reg_addr <= at[rnd[3:2]];
      reg_wdata <= rnd[31:16];
      standby <= rnd[5:4] != 2'b00;
      ri <= 30'($urandom);
      @(negedge mclk);
      check("gout_switch_openwire", e[30:25], vout[30:25]);
      check("bias_magnitude", e[24:11], vout[24:11]);
      check("route", e[10:3], vout[10:3]);
      check("ref_holder", e[2], vout[2]);
      check("internal_ref", e[1:0], vout[1:0]);
      check("rdata", er, reg_rdata_q);
    end
    test_done();
  end
endmodule // skac_standby_keep_alive_bench
